// ===== core/lane_test_regs.vh
// Purpose: register offsets, fields, reset values and timing for lane status and bit-error test
// Assumes: 15-bit serial-port addresses, 8-bit registers
// Notes: included by the lane test top and its lane checker
`ifndef LANE_TEST_REGS_VH
`define LANE_TEST_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define ADDR_FIFO_EMPTY 15'h030d
`define ADDR_SYNC_PULSE 15'h0312
`define ADDR_CFG_CLK_SEL 15'h0314
`define ADDR_LANE_ENABLE 15'h0315
`define ADDR_TEST_CTRL 15'h0316
`define ADDR_LIMIT_LOW 15'h0317
`define ADDR_LIMIT_MID 15'h0318
`define ADDR_LIMIT_HIGH 15'h0319
`define ADDR_ERRORS_LOW 15'h031a
`define ADDR_ERRORS_MID 15'h031b
`define ADDR_ERRORS_HIGH 15'h031c
`define ADDR_PASS_FLAGS 15'h031d

////////////////////////////////////////////////////////////////////////////////
// fields of the control registers
`define PULSE_LEN_MSB 5
`define PULSE_LEN_LSB 4
`define CTRL_SEL_MSB 6
`define CTRL_SEL_LSB 4
`define CTRL_PAT_MSB 3
`define CTRL_PAT_LSB 2
`define CTRL_RUN_BIT 1
`define CTRL_CLEAR_BIT 0
`define CTRL_WRITE_MASK 8'h7f
`define CFG_CLK_SEL_MASK 8'h01

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_ZERO 8'h00
`define RST_PASS_FLAGS 8'hff

////////////////////////////////////////////////////////////////////////////////
// pattern codes
`define PAT_PRBS7 2'h0
`define PAT_PRBS15 2'h1
`define PAT_PRBS31 2'h2
`define PAT_UNUSED 2'h3

////////////////////////////////////////////////////////////////////////////////
// timing: lane clock period in system clock cycles, and pulse length codes
`define PCLK_DIV 2
`define PULSE_HALF 2'h0
`define PULSE_ONE 2'h1
`define PULSE_TWO 2'h2
// bits taken into the checker history before mismatches count
`define PRBS_FILL 5'h1f

`endif

// ===== core/prbs_lane_checker.v
// Purpose: one lane of the bit-error test: self-aligning sequence check and error count
// Assumes: rx_bit is qualified by bit_valid from deserializer logic on clk_sys
// Notes: the count saturates; fail is sticky until clear
`timescale 1ns/1ns
`include "lane_test_regs.vh"

module prbs_lane_checker #(
    parameter CNT_W = 24
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_b,
    // control
    input wire run,
    input wire clear,
    input wire [1:0] pattern,
    input wire [CNT_W-1:0] threshold,
    // lane data
    input wire bit_valid,
    input wire rx_bit,
    // results
    output reg [CNT_W-1:0] error_count,
    output reg fail
);

reg [30:0] history_reg;
reg [4:0] fill_reg;
reg expected;
reg checked;

// the expected bit comes from the received history itself, so the
// checker locks to any phase of the sequence without a seed
always @* begin
    expected = 1'b0;
    checked = 1'b1;
    case (pattern)
        `PAT_PRBS7: expected = history_reg[6] ^ history_reg[5];
        `PAT_PRBS15: expected = history_reg[14] ^ history_reg[13];
        `PAT_PRBS31: expected = history_reg[30] ^ history_reg[27];
        default: checked = 1'b0;
    endcase
end

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        history_reg <= 31'h00000000;
        fill_reg <= 5'h00;
        error_count <= {CNT_W{1'b0}};
        fail <= 1'b0;
    end else if (clear) begin
        history_reg <= 31'h00000000;
        fill_reg <= 5'h00;
        error_count <= {CNT_W{1'b0}};
        fail <= 1'b0;
    end else begin
        if (run && bit_valid) begin
            history_reg <= {history_reg[29:0], rx_bit};
            if (fill_reg != `PRBS_FILL) begin
                fill_reg <= fill_reg + 5'h01;
            end else if (checked && (rx_bit != expected) && (~&error_count)) begin
                error_count <= error_count + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
        if (error_count > threshold) begin
            fail <= 1'b1;
        end
    end
end

endmodule // prbs_lane_checker

// ===== core/lane_test_top.v
// Purpose: lane status, sync error pulse and lane bit-error test behind the serial port
// Assumes: serial clock at most one eighth of clk_sys; lane bits and link events on clk_sys
// Notes: serial frame is 16 instruction bits (read flag, 15-bit address) then data bytes
//   unused pulse length code is held as long as the longest one
//   pass flags follow the lane fail flags one cycle later
`timescale 1ns/1ns
`include "lane_test_regs.vh"

module lane_test_top #(
    parameter LANES = 8,
    parameter LINKS = 2,
    parameter CNT_W = 24,
    parameter PCLK_DIV = `PCLK_DIV
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_b,
    // serial control port
    input wire spi_sclk,
    input wire spi_cs_b,
    input wire spi_sdi,
    output reg spi_sdo,
    output reg spi_sdo_oe,
    // lane side, from deserializer logic
    input wire [LANES-1:0] lane_fifo_empty,
    input wire [LANES-1:0] lane_bit_valid,
    input wire [LANES-1:0] lane_rx_bit,
    // link side, from the deframers
    input wire [LINKS-1:0] multiframe_end,
    input wire [LINKS-1:0] char_error,
    // outputs
    output reg sync_request_out_link0_b,
    output reg sync_request_out_link1_b,
    output reg serdes_config_clk_sel
);

////////////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] fifo_empty_reg;
reg [7:0] sync_pulse_reg;
reg [7:0] lane_enable_reg;
reg [7:0] test_ctrl_reg;
reg [7:0] limit_low_reg;
reg [7:0] limit_mid_reg;
reg [7:0] limit_high_reg;
reg [7:0] pass_flags_reg;

wire [1:0] error_pulse_length = sync_pulse_reg[`PULSE_LEN_MSB:`PULSE_LEN_LSB];
wire [2:0] error_count_lane_select = test_ctrl_reg[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
wire [1:0] bert_pattern_choice = test_ctrl_reg[`CTRL_PAT_MSB:`CTRL_PAT_LSB];
wire bert_run = test_ctrl_reg[`CTRL_RUN_BIT];
wire bert_clear = test_ctrl_reg[`CTRL_CLEAR_BIT];
// threshold bytes stand high to low, so the three writes may come in any order
wire [CNT_W-1:0] bert_limit = {limit_high_reg, limit_mid_reg, limit_low_reg};

wire [LANES*CNT_W-1:0] lane_counts;
wire [LANES-1:0] lane_fail;
reg [CNT_W-1:0] sel_count;

// a select beyond the last lane reads zero instead of an unknown slice
always @* begin : count_mux
    integer j;
    sel_count = {CNT_W{1'b0}};
    for (j = 0; j < LANES; j = j + 1) begin
        if ({29'h0, error_count_lane_select} == j) begin
            sel_count = lane_counts[j*CNT_W +: CNT_W];
        end
    end
end

// serial-port write strobe
reg wr_stb;
reg [14:0] wr_addr;
reg [7:0] wr_data;

////////////////////////////////////////////////////////////////////////////////
// read decode

function [7:0] read_mux;
    input [14:0] addr;
    begin
        case (addr)
            `ADDR_FIFO_EMPTY: read_mux = fifo_empty_reg;
            `ADDR_SYNC_PULSE: read_mux = sync_pulse_reg;
            `ADDR_CFG_CLK_SEL: read_mux = {7'h00, serdes_config_clk_sel};
            `ADDR_LANE_ENABLE: read_mux = lane_enable_reg;
            `ADDR_TEST_CTRL: read_mux = test_ctrl_reg;
            `ADDR_LIMIT_LOW: read_mux = limit_low_reg;
            `ADDR_LIMIT_MID: read_mux = limit_mid_reg;
            `ADDR_LIMIT_HIGH: read_mux = limit_high_reg;
            `ADDR_ERRORS_LOW: read_mux = sel_count[7:0];
            `ADDR_ERRORS_MID: read_mux = sel_count[15:8];
            `ADDR_ERRORS_HIGH: read_mux = sel_count[23:16];
            `ADDR_PASS_FLAGS: read_mux = pass_flags_reg;
            default: read_mux = 8'h00;
        endcase
    end
endfunction

// the half cycle is exact only for an even PCLK_DIV
localparam [31:0] HALF_CYCLES = PCLK_DIV / 2;
localparam [31:0] ONE_CYCLES = PCLK_DIV;
localparam [31:0] TWO_CYCLES = 2 * PCLK_DIV;

// number of clk_sys cycles the sync request is held low per length code
function [3:0] pulse_cycles;
    input [1:0] code;
    begin
        case (code)
            `PULSE_HALF: pulse_cycles = HALF_CYCLES[3:0];
            `PULSE_ONE: pulse_cycles = ONE_CYCLES[3:0];
            `PULSE_TWO: pulse_cycles = TWO_CYCLES[3:0];
            // the unused code is held like the longest to stay visible
            default: pulse_cycles = TWO_CYCLES[3:0];
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// serial port: pins pass two flops; sclk gets a third for edge detection

reg sclk_s1;
reg sclk_s2;
reg sclk_s3;
reg cs_s1;
reg cs_s2;
reg sdi_s1;
reg sdi_s2;

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        sclk_s1 <= 1'b0;
        sclk_s2 <= 1'b0;
        sclk_s3 <= 1'b0;
        cs_s1 <= 1'b1;
        cs_s2 <= 1'b1;
        sdi_s1 <= 1'b0;
        sdi_s2 <= 1'b0;
    end else begin
        sclk_s1 <= spi_sclk;
        sclk_s2 <= sclk_s1;
        sclk_s3 <= sclk_s2;
        cs_s1 <= spi_cs_b;
        cs_s2 <= cs_s1;
        sdi_s1 <= spi_sdi;
        sdi_s2 <= sdi_s1;
    end
end

wire sclk_rise = sclk_s2 & ~sclk_s3;
wire sclk_fall = ~sclk_s2 & sclk_s3;

reg [4:0] bit_cnt_reg;
reg [14:0] instr_reg;
reg [14:0] addr_reg;
reg read_reg;
reg [6:0] wr_shift_reg;
reg [6:0] rd_shift_reg;

// after each data byte the address steps on, so bursts stream through the map
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        bit_cnt_reg <= 5'h00;
        instr_reg <= 15'h0000;
        addr_reg <= 15'h0000;
        read_reg <= 1'b0;
        wr_shift_reg <= 7'h00;
        rd_shift_reg <= 7'h00;
        wr_stb <= 1'b0;
        wr_addr <= 15'h0000;
        wr_data <= 8'h00;
        spi_sdo <= 1'b0;
        spi_sdo_oe <= 1'b0;
    end else begin
        wr_stb <= 1'b0;
        // chip select high mid byte drops the byte: no partial write lands
        if (cs_s2) begin
            bit_cnt_reg <= 5'h00;
            read_reg <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else begin
            if (sclk_rise) begin
                if (bit_cnt_reg < 5'h10) begin
                    instr_reg <= {instr_reg[13:0], sdi_s2};
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    if (bit_cnt_reg == 5'h0f) begin
                        addr_reg <= {instr_reg[13:0], sdi_s2};
                        read_reg <= instr_reg[14];
                    end
                end else if (bit_cnt_reg == 5'h17) begin
                    if (!read_reg) begin
                        wr_stb <= 1'b1;
                        wr_addr <= addr_reg;
                        wr_data <= {wr_shift_reg, sdi_s2};
                    end
                    addr_reg <= addr_reg + 15'h0001;
                    bit_cnt_reg <= 5'h10;
                end else begin
                    wr_shift_reg <= {wr_shift_reg[5:0], sdi_s2};
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                end
            end
            if (sclk_fall && read_reg && (bit_cnt_reg >= 5'h10)) begin
                spi_sdo_oe <= 1'b1;
                if (bit_cnt_reg == 5'h10) begin
                    // the byte is taken whole so a status change cannot tear it
                    {spi_sdo, rd_shift_reg} <= read_mux(addr_reg);
                end else begin
                    spi_sdo <= rd_shift_reg[6];
                    rd_shift_reg <= {rd_shift_reg[5:0], 1'b0};
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// register file
// reserved bits of the pulse setting are stored and read back as written

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        sync_pulse_reg <= `RST_ZERO;
        serdes_config_clk_sel <= 1'b0;
        lane_enable_reg <= `RST_ZERO;
        test_ctrl_reg <= `RST_ZERO;
        limit_low_reg <= `RST_ZERO;
        limit_mid_reg <= `RST_ZERO;
        limit_high_reg <= `RST_ZERO;
    end else if (wr_stb) begin
        case (wr_addr)
            `ADDR_SYNC_PULSE: sync_pulse_reg <= wr_data;
            // kept at zero by software during physical layer setup
            `ADDR_CFG_CLK_SEL: serdes_config_clk_sel <= wr_data[0];
            `ADDR_LANE_ENABLE: lane_enable_reg <= wr_data;
            `ADDR_TEST_CTRL: test_ctrl_reg <= wr_data & `CTRL_WRITE_MASK;
            `ADDR_LIMIT_LOW: limit_low_reg <= wr_data;
            `ADDR_LIMIT_MID: limit_mid_reg <= wr_data;
            `ADDR_LIMIT_HIGH: limit_high_reg <= wr_data;
            default: ;
        endcase
    end
end

// status snapshots for readback
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        fifo_empty_reg <= `RST_ZERO;
        pass_flags_reg <= `RST_PASS_FLAGS;
    end else begin
        fifo_empty_reg <= lane_fifo_empty;
        pass_flags_reg <= ~lane_fail;
    end
end

////////////////////////////////////////////////////////////////////////////////
// lane bit-error checkers

genvar g;
generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
        // a disabled lane holds its history and count as they stand, but the shared clear still zeroes them
        wire lane_run = bert_run & lane_enable_reg[g];
        prbs_lane_checker #(
            .CNT_W(CNT_W)
        ) bit_check (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .run(lane_run),
            .clear(bert_clear),
            .pattern(bert_pattern_choice),
            .threshold(bert_limit),
            .bit_valid(lane_bit_valid[g]),
            .rx_bit(lane_rx_bit[g]),
            .error_count(lane_counts[g*CNT_W +: CNT_W]),
            .fail(lane_fail[g])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// sync error pulse per link

reg [LINKS-1:0] sync_low_next;
wire [4*LINKS-1:0] pulse_cnt_flat;

generate
    for (g = 0; g < LINKS; g = g + 1) begin : link
        reg [3:0] pulse_cnt_reg;
        reg [3:0] pulse_cnt_next;
        reg err_seen_reg;
        // an error seen in the closing cycle still counts for this multiframe
        wire close_with_error = multiframe_end[g] && (err_seen_reg || char_error[g]);
        // a new erroneous close reloads the count, so close pulses merge
        always @* begin
            pulse_cnt_next = pulse_cnt_reg;
            if (close_with_error) begin
                pulse_cnt_next = pulse_cycles(error_pulse_length);
            end else if (pulse_cnt_reg != 4'h0) begin
                pulse_cnt_next = pulse_cnt_reg - 4'h1;
            end
        end
        always @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                pulse_cnt_reg <= 4'h0;
                err_seen_reg <= 1'b0;
            end else begin
                pulse_cnt_reg <= pulse_cnt_next;
                if (multiframe_end[g]) begin
                    err_seen_reg <= 1'b0;
                end else if (char_error[g]) begin
                    err_seen_reg <= 1'b1;
                end
            end
        end
        assign pulse_cnt_flat[4*g +: 4] = pulse_cnt_next;
    end
endgenerate

always @* begin : low_decode
    integer i;
    sync_low_next = {LINKS{1'b0}};
    for (i = 0; i < LINKS; i = i + 1) begin
        sync_low_next[i] = (pulse_cnt_flat[4*i +: 4] != 4'h0);
    end
end

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        sync_request_out_link0_b <= 1'b1;
        sync_request_out_link1_b <= 1'b1;
    end else begin
        sync_request_out_link0_b <= ~sync_low_next[0];
        sync_request_out_link1_b <= ~sync_low_next[1];
    end
end

endmodule // lane_test_top

// ===== verif/bert_lane_source.sv
// Purpose: transmitter model sending the bit-error test sequence on all eight lanes
// Assumes: one bit per lane every second clk_sys cycle
// Notes: flip_req corrupts the next bit of the chosen lanes once
`timescale 1ns/1ns
module bert_lane_source (
    // clock and reset
    input wire clk_sys,
    input wire rst_b,
    // control from the bench
    input wire [1:0] pattern,
    input wire [7:0] flip_req,
    // lanes
    output reg [7:0] bit_valid,
    output reg [7:0] rx_bit
);
    reg [30:0] hist_reg;
    reg [7:0] pend_reg;
    reg tick_reg;
    reg nb;
    always @* begin
        case (pattern)
            2'h1: nb = hist_reg[14] ^ hist_reg[13];
            2'h2: nb = hist_reg[30] ^ hist_reg[27];
            default: nb = hist_reg[6] ^ hist_reg[5];
        endcase
    end
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hist_reg <= 31'h7fffffff;
            pend_reg <= 8'h00;
            tick_reg <= 1'b0;
            bit_valid <= 8'h00;
            rx_bit <= 8'h00;
        end else begin
            tick_reg <= ~tick_reg;
            pend_reg <= tick_reg ? flip_req : (pend_reg | flip_req);
            bit_valid <= {8{tick_reg}};
            if (tick_reg) begin
                hist_reg <= {hist_reg[29:0], nb};
                rx_bit <= {8{nb}} ^ pend_reg;
            end else begin
                // no stale bit between valid strobes
                rx_bit <= ~rx_bit;
            end
        end
    end
endmodule // bert_lane_source

// ===== verif/lane_test_chk.sv
// Purpose: port-level checks of sync request pulses and serial port output enable
// Assumes: single clock domain, clk_sys
// Notes: pulse length is bounded by the longest code since the setting is not visible
`timescale 1ns/1ns
module lane_test_chk #(
    parameter LINKS = 2
) (
    input wire clk_sys,
    input wire rst_b,
    input wire spi_cs_b,
    input wire spi_sdo_oe,
    input wire [LINKS-1:0] multiframe_end,
    input wire [LINKS-1:0] char_error,
    input wire sync_request_out_link0_b,
    input wire sync_request_out_link1_b,
    input wire serdes_config_clk_sel
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_close0;
        multiframe_end[0] && char_error[0];
    endsequence
    sequence s_close1;
        multiframe_end[1] && char_error[1];
    endsequence
    sequence s_low0;
        (!sync_request_out_link0_b && !multiframe_end[0])[*4];
    endsequence
    sequence s_low1;
        (!sync_request_out_link1_b && !multiframe_end[1])[*4];
    endsequence
    a_sync0_err: assert property (s_close0 |=> !sync_request_out_link0_b)
        else $error("link0 sync not lowered after error");
    a_sync1_err: assert property (s_close1 |=> !sync_request_out_link1_b)
        else $error("link1 sync not lowered after error");
    a_sync0_cause: assert property ($fell(sync_request_out_link0_b) |-> $past(multiframe_end[0]))
        else $error("link0 sync fell without multiframe end");
    a_sync1_cause: assert property ($fell(sync_request_out_link1_b) |-> $past(multiframe_end[1]))
        else $error("link1 sync fell without multiframe end");
    a_sync0_len: assert property (s_low0 |=> sync_request_out_link0_b)
        else $error("link0 sync low too long");
    a_sync1_len: assert property (s_low1 |=> sync_request_out_link1_b)
        else $error("link1 sync low too long");
    a_oe_idle: assert property (spi_cs_b [*5] |-> !spi_sdo_oe)
        else $error("sdo driven outside a frame");
    a_oe_frame: assert property ($rose(spi_sdo_oe) |-> !spi_cs_b)
        else $error("sdo enable rose without chip select");
    a_clksel_hold: assert property (spi_cs_b [*5] |=> $stable(serdes_config_clk_sel))
        else $error("clock select changed outside a frame");
endmodule // lane_test_chk

bind lane_test_top lane_test_chk #(.LINKS(LINKS)) chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .spi_cs_b(spi_cs_b), .spi_sdo_oe(spi_sdo_oe), .multiframe_end(multiframe_end),
    .char_error(char_error), .sync_request_out_link0_b(sync_request_out_link0_b),
    .sync_request_out_link1_b(sync_request_out_link1_b),
    .serdes_config_clk_sel(serdes_config_clk_sel));

// ===== verif/lane_test_top_tb.sv
// Purpose: self-checking bench for lane status, sync pulses and lane bit-error test
// Assumes: serial clock low for six clk_sys cycles and high for five
// Notes: one flipped bit costs three counts in a self-synchronising checker
`timescale 1ns/1ns
module lane_test_top_tb;
    localparam DIV = 2;
    reg clk_sys, rst_b, spi_sclk, spi_cs_b, spi_sdi;
    reg [7:0] fifo_e, flip, rd, v;
    reg [1:0] mfe, cerr, pat;
    reg [14:0] a;
    reg [23:0] thr;
    reg [31:0] r;
    wire [7:0] bv, rb;
    wire sdo, oe, s0, s1, csel;
    integer seed, err_total, num_checks, i, k;
    lane_test_top #(.PCLK_DIV(DIV)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .spi_sclk(spi_sclk),
        .spi_cs_b(spi_cs_b), .spi_sdi(spi_sdi), .spi_sdo(sdo), .spi_sdo_oe(oe),
        .lane_fifo_empty(fifo_e), .lane_bit_valid(bv), .lane_rx_bit(rb), .multiframe_end(mfe),
        .char_error(cerr), .sync_request_out_link0_b(s0), .sync_request_out_link1_b(s1),
        .serdes_config_clk_sel(csel));
    bert_lane_source src (.clk_sys(clk_sys), .rst_b(rst_b), .pattern(pat), .flip_req(flip),
        .bit_valid(bv), .rx_bit(rb));
    ////////////////////////////////////////////////////////////////////////////////
    function [7:0] exp_rw(input [14:0] ad, input [7:0] d);
        begin
            case (ad)
                15'h0312, 15'h0315, 15'h0317, 15'h0318, 15'h0319: exp_rw = d;
                15'h0314: exp_rw = d & 8'h01;
                15'h0316: exp_rw = d & 8'h7f;
                15'h031d: exp_rw = 8'hff;
                default: exp_rw = 8'h00;
            endcase
        end
    endfunction
    function [7:0] pulse_len(input [1:0] c);
        begin
            pulse_len = (c == 2'h0) ? DIV / 2 : (c == 2'h1) ? DIV : 2 * DIV;
        end
    endfunction
    task tick(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    task finish_test;
        begin
            if (err_total == 0 && num_checks > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    task cmp(input [127:0] what, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("unexpected %0s: expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // one frame: read flag, address, one data byte; sdo sampled half a clk_sys cycle before sclk rises
    task spi(input rw, input [14:0] ad, input [7:0] wd);
        reg [23:0] f;
        integer b;
        begin
            f = {rw, ad, wd};
            spi_cs_b <= 1'b0;
            tick(1);
            for (b = 23; b >= 0; b = b - 1) begin
                spi_sclk <= 1'b0;
                spi_sdi <= f[b];
                tick(5);
                @(negedge clk_sys);
                if (b < 8) rd[b] = sdo;
                @(posedge clk_sys);
                spi_sclk <= 1'b1;
                tick(5);
            end
            tick(3);
            spi_sclk <= 1'b0;
            spi_cs_b <= 1'b1;
            tick(6);
        end
    endtask
    task wr(input [14:0] ad, input [7:0] d);
        spi(1'b0, ad, d);
    endtask
    task chk_rd(input [127:0] what, input [14:0] ad, input [7:0] e);
        begin
            spi(1'b1, ad, 8'h00);
            cmp(what, e, rd);
        end
    endtask
    // e[0]: error inside the multiframe, e[1]: error in its closing cycle
    task sync_try(input integer l, input [1:0] e, input [7:0] exp);
        reg [7:0] n;
        begin
            cerr[l] <= e[0];
            tick(1);
            cerr[l] <= 1'b0;
            tick(2);
            mfe[l] <= 1'b1;
            cerr[l] <= e[1];
            tick(1);
            mfe[l] <= 1'b0;
            cerr[l] <= 1'b0;
            n = 8'h00;
            repeat (8) begin
                @(negedge clk_sys);
                if (((l == 0) ? s0 : s1) === 1'b0) n = n + 8'h01;
            end
            cmp("sync low cycles", exp, n);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        #(50 * 90000);
        err_total = err_total + 1;
        finish_test;
    end
    initial begin
        seed = 86704;
        err_total = 0;
        num_checks = 0;
        {rst_b, spi_sclk, spi_sdi, fifo_e, flip, mfe, cerr, pat} = 0;
        spi_cs_b = 1'b1;
        tick(3);
        rst_b <= 1'b1;
        tick(3);
        for (i = 0; i < 17; i = i + 1) begin
            a = 15'h030d + i[14:0];
            chk_rd("reset value", a, exp_rw(a, 8'h00));
        end
        for (i = 0; i < 17; i = i + 1) begin
            a = 15'h030d + i[14:0];
            r = $random(seed);
            v = (a == 15'h0316) ? r[7:0] & 8'hfc : r[7:0];
            wr(a, v);
            chk_rd("register", a, exp_rw(a, v));
            if (a == 15'h0314) cmp("clock select pin", {7'h00, v[0]}, {7'h00, csel});
        end
        wr(15'h0314, 8'h00);
        cmp("clock select pin", 8'h00, {7'h00, csel});
        for (i = 0; i < 3; i = i + 1) begin
            r = $random(seed);
            fifo_e <= (i == 0) ? 8'hff : r[7:0];
            tick(1);
            chk_rd("fifo empty", 15'h030d, fifo_e);
        end
        sync_try(0, 2'b00, 8'h00);
        for (k = 0; k < 4; k = k + 1) begin
            wr(15'h0312, {2'b00, k[1:0], 4'h0});
            sync_try(0, {k[0], ~k[0]}, pulse_len(k[1:0]));
            sync_try(1, {k[0], ~k[0]}, pulse_len(k[1:0]));
        end
        wr(15'h0315, 8'h03);
        for (k = 0; k < 4; k = k + 1) begin
            thr = (k == 0) ? 24'h2 : (k == 1) ? 24'h3 : (k == 2) ? 24'h010000 : 24'h0;
            pat <= k[1:0];
            wr(15'h0316, {4'h1, k[1:0], 2'b01});
            wr(15'h0317, thr[7:0]);
            wr(15'h0318, thr[15:8]);
            wr(15'h0319, thr[23:16]);
            wr(15'h0316, {4'h1, k[1:0], 2'b10});
            tick(100);
            flip <= 8'h06;
            tick(1);
            flip <= 8'h00;
            tick(100);
            wr(15'h0316, {4'h1, k[1:0], 2'b00});
            // a flip after the stop must not be counted
            flip <= 8'h02;
            tick(1);
            flip <= 8'h00;
            tick(100);
            v = (k == 3) ? 8'h00 : 8'h03;
            chk_rd("count low", 15'h031a, v);
            chk_rd("count mid", 15'h031b, 8'h00);
            chk_rd("count high", 15'h031c, 8'h00);
            chk_rd("pass flags", 15'h031d, ({16'h0, v} > thr) ? 8'hfd : 8'hff);
            wr(15'h0316, {4'h2, k[1:0], 2'b00});
            chk_rd("disabled lane", 15'h031a, 8'h00);
            wr(15'h0316, {4'h1, k[1:0], 2'b01});
            chk_rd("cleared count", 15'h031a, 8'h00);
            chk_rd("cleared pass", 15'h031d, 8'hff);
        end
        finish_test;
    end
endmodule // lane_test_top_tb
